// *** design/bcd_digit_add.sv ***
// One packed decimal digit adder with carry in and carry out.
`timescale 1ns/1ns
`default_nettype none
`include "exec_unit_consts.svh"
module bcd_digit_add (
    input  wire exec_unit_pkg::digit_t a,
    input  wire exec_unit_pkg::digit_t b,
    input  wire logic                  carry_in,
    output exec_unit_pkg::digit_t      sum,
    output logic                       carry_out
);
    import exec_unit_pkg::*;

    logic [4:0] raw;
    logic [4:0] fixed;

    always_comb begin
        raw       = {1'b0, a} + {1'b0, b} + {4'h0, carry_in};
        carry_out = raw > `BCD_NINE;
        fixed     = carry_out ? raw + `BCD_SIX : raw;
        sum       = fixed[3:0];
    end
endmodule
`default_nettype wire

// *** design/exec_unit.sv ***
// Execution unit for decimal add, decrement and interrupt enable operations.
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "exec_unit_consts.svh"
module exec_unit (
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    input  wire logic [7:0]            addr,
    input  wire exec_unit_pkg::word_t  wr_data,
    input  wire logic                  wr_en,
    input  wire logic                  rd_en,
    input  wire logic                  irq_request,
    output exec_unit_pkg::word_t       rd_data,
    output logic                       global_irq_enable,
    output logic                       irq_take,
    output logic                       exec_done
);
    import exec_unit_pkg::*;

    // ****************************************************************
    // Functions
    // ****************************************************************

    function automatic exec_op_t decode_op(input logic [2:0] code);
        unique case (code)
            `OPC_DECIMAL_ADD: decode_op = decimal_add_op;
            `OPC_CARRY_ADD:   decode_op = add_carry_decimal_op;
            `OPC_SUB_ONE:     decode_op = decrement_one_op;
            `OPC_SUB_TWO:     decode_op = decrement_two_op;
            `OPC_IRQ_OFF:     decode_op = interrupts_off_op;
            `OPC_IRQ_ON:      decode_op = interrupts_on_op;
            default:          decode_op = op_none;
        endcase
    endfunction

    // Byte results keep only the low byte; the high byte reads zero.
    function automatic word_t size_mask(input word_t val, input logic byte_mode);
        size_mask = byte_mode ? (val & `BYTE_MASK) : val;
    endfunction

    function automatic logic sign_of(input word_t val, input logic byte_mode);
        sign_of = byte_mode ? val[7] : val[15];
    endfunction

    // ****************************************************************
    // Registers and decode
    // ****************************************************************

    word_t    src_reg;
    word_t    dst_reg;
    word_t    stat_reg;
    word_t    dst_next;
    word_t    stat_next;
    word_t    rd_data_reg;
    logic     exec_done_reg;
    logic     irq_take_reg;
    logic     shadow_reg;
    logic     shadow_next;
    logic     req_meta_reg;
    logic     req_sync_reg;
    logic     exec_go;
    logic     byte_sel;
    exec_op_t op;

    assign exec_go  = wr_en && (addr == `ADDR_CMD);
    assign op       = decode_op(wr_data[`CMD_OP_MSB:`CMD_OP_LSB]);
    assign byte_sel = wr_data[`CMD_BYTE_BIT];

    // ****************************************************************
    // Decimal adder
    // ****************************************************************

    word_t      addend;
    word_t      bcd_sum;
    logic [4:0] dcarry;
    logic       bcd_carry;

    // carry-only decimal add uses zero addend
    assign addend    = (op == add_carry_decimal_op) ? `WORD_ZERO : src_reg;
    assign dcarry[0] = stat_reg[`STAT_C_BIT];

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_digit
            bcd_digit_add u_digit (
                .a         (dst_reg[4*gi +: 4]),
                .b         (addend[4*gi +: 4]),
                .carry_in  (dcarry[gi]),
                .sum       (bcd_sum[4*gi +: 4]),
                .carry_out (dcarry[gi+1])
            );
        end
    endgenerate

    // decimal overflow from the top digit of the size
    assign bcd_carry = byte_sel ? dcarry[2] : dcarry[4];

    // ****************************************************************
    // Decrement
    // ****************************************************************

    word_t step;
    word_t sub_diff;
    word_t dst_sized;
    logic  sub_borrow;
    logic  sub_ovf;

    // subtract the constant one or two
    assign step      = (op == decrement_two_op) ? `STEP_TWO : `STEP_ONE;
    assign dst_sized = size_mask(dst_reg, byte_sel);
    assign sub_diff  = size_mask(dst_sized - step, byte_sel);
    assign sub_borrow = dst_sized < step;
    // positive result from a negative start
    assign sub_ovf    = sign_of(dst_sized, byte_sel) && !sign_of(sub_diff, byte_sel);

    // ****************************************************************
    // Execution
    // ****************************************************************

    always_comb begin
        dst_next  = dst_reg;
        stat_next = stat_reg;
        unique case (op)
            decimal_add_op, add_carry_decimal_op: begin
                dst_next = size_mask(bcd_sum, byte_sel);
                stat_next[`STAT_N_BIT] = sign_of(dst_next, byte_sel);
                stat_next[`STAT_Z_BIT] = (dst_next == `WORD_ZERO);
                stat_next[`STAT_C_BIT] = bcd_carry;
                // overflow flag is left as it was
            end
            decrement_one_op, decrement_two_op: begin
                dst_next = sub_diff;
                stat_next[`STAT_N_BIT] = sign_of(sub_diff, byte_sel);
                // zero only when start equalled step
                stat_next[`STAT_Z_BIT] = (sub_diff == `WORD_ZERO);
                stat_next[`STAT_C_BIT] = !sub_borrow;
                // overflow on crossing the most negative
                stat_next[`STAT_V_BIT] = sub_ovf;
            end
            interrupts_off_op: begin
                stat_next = stat_reg & ~`IRQ_EN_MASK;
            end
            interrupts_on_op: begin
                stat_next = stat_reg | `IRQ_EN_MASK;
            end
            op_none: begin
                stat_next = stat_reg;
            end
        endcase
        // arithmetic never touches halt or enable bits
        // enable operations never touch the other bits
        stat_next[`STAT_CORE_BIT]   = stat_reg[`STAT_CORE_BIT];
        stat_next[`STAT_OSC_BIT]    = stat_reg[`STAT_OSC_BIT];
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            src_reg <= `WORD_ZERO;
        end else if (wr_en && addr == `ADDR_SRC) begin
            src_reg <= wr_data;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dst_reg <= `WORD_ZERO;
        end else if (exec_go) begin
            dst_reg <= dst_next;
        end else if (wr_en && addr == `ADDR_DST) begin
            dst_reg <= wr_data;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stat_reg <= `STAT_RESET;
        end else if (exec_go) begin
            stat_reg <= stat_next;
        end else if (wr_en && addr == `ADDR_STAT) begin
            stat_reg <= wr_data;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            exec_done_reg <= 1'b0;
        end else begin
            exec_done_reg <= exec_go;
        end
    end

    // ****************************************************************
    // Interrupt acceptance
    // ****************************************************************

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            req_meta_reg <= 1'b0;
            req_sync_reg <= 1'b0;
        end else begin
            req_meta_reg <= irq_request;
            req_sync_reg <= req_meta_reg;
        end
    end

    // hold off acceptance until the next operation runs
    always_comb begin
        shadow_next = shadow_reg;
        if (exec_go) begin
            shadow_next = (op == interrupts_on_op);
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            shadow_reg <= 1'b0;
        end else begin
            shadow_reg <= shadow_next;
        end
    end

    // no acceptance while the shadow is active
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_take_reg <= 1'b0;
        end else begin
            irq_take_reg <= stat_reg[`STAT_IRQ_EN_BIT] && req_sync_reg && !shadow_next;
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_reg <= `WORD_ZERO;
        end else if (rd_en) begin
            unique case (addr)
                `ADDR_SRC:   rd_data_reg <= src_reg;
                `ADDR_DST:   rd_data_reg <= dst_reg;
                `ADDR_STAT:  rd_data_reg <= stat_reg;
                `ADDR_STATE: rd_data_reg <= {13'h0000, irq_take_reg, req_sync_reg, shadow_reg};
                default:     rd_data_reg <= `WORD_ZERO;
            endcase
        end else begin
            rd_data_reg <= `WORD_ZERO;
        end
    end

    assign rd_data           = rd_data_reg;
    assign exec_done         = exec_done_reg;
    assign irq_take          = irq_take_reg;
    assign global_irq_enable = stat_reg[`STAT_IRQ_EN_BIT];

    // ****************************************************************
    // Assertions
    // ****************************************************************

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    bcd_neg_flag_a: assert property (
        $past(exec_go && op == decimal_add_op) |->
            stat_reg[`STAT_N_BIT] == sign_of(dst_reg, $past(byte_sel)))
        else $error("decimal add negative flag wrong");

    bcd_zero_flag_a: assert property (
        $past(exec_go && op == decimal_add_op) |-> stat_reg[`STAT_Z_BIT] == (dst_reg == `WORD_ZERO))
        else $error("decimal add zero flag wrong");

    bcd_word_carry_a: assert property (
        (exec_go && op == decimal_add_op && !byte_sel && src_reg == `STEP_ONE
         && dst_reg == `BCD_WORD_MAX && !stat_reg[`STAT_C_BIT]) |=>
            dst_reg == `WORD_ZERO && stat_reg[`STAT_C_BIT] && src_reg == $past(src_reg))
        else $error("decimal add word overflow wrong");

    carry_roll_a: assert property (
        (exec_go && op == add_carry_decimal_op && byte_sel && dst_reg == `BCD_BYTE_MAX
         && stat_reg[`STAT_C_BIT]) |=> dst_reg == `WORD_ZERO && stat_reg[`STAT_C_BIT])
        else $error("carry-only decimal rollover wrong");

    sub_one_a: assert property (
        $past(exec_go && op == decrement_one_op) |->
            dst_reg == size_mask($past(dst_sized) - `STEP_ONE, $past(byte_sel))
            && stat_reg[`STAT_Z_BIT] == ($past(dst_sized) == `STEP_ONE))
        else $error("decrement by one result or zero wrong");

    sub_one_carry_a: assert property (
        $past(exec_go && op == decrement_one_op) |->
            stat_reg[`STAT_C_BIT] == ($past(dst_sized) != `WORD_ZERO))
        else $error("decrement by one carry wrong");

    sub_one_ovf_a: assert property (
        $past(exec_go && op == decrement_one_op) |-> stat_reg[`STAT_V_BIT] ==
            ($past(dst_sized) == ($past(byte_sel) ? `BYTE_MIN_NEG : `WORD_MIN_NEG)))
        else $error("decrement by one overflow wrong");

    sub_two_a: assert property (
        $past(exec_go && op == decrement_two_op) |->
            stat_reg[`STAT_Z_BIT] == ($past(dst_sized) == `STEP_TWO)
            && stat_reg[`STAT_C_BIT] == ($past(dst_sized) > `STEP_ONE))
        else $error("decrement by two zero or carry wrong");

    sub_two_ovf_a: assert property (
        $past(exec_go && op == decrement_two_op && !byte_sel) |-> stat_reg[`STAT_V_BIT] ==
            ($past(dst_sized) == `WORD_MIN_NEG || $past(dst_sized) == `WORD_MIN_NEG_P1))
        else $error("decrement by two overflow wrong");

    irq_off_a: assert property (
        $past(exec_go && op == interrupts_off_op) |-> stat_reg == ($past(stat_reg) & ~`IRQ_EN_MASK))
        else $error("interrupts off changed wrong bits");

    irq_on_a: assert property (
        $past(exec_go && op == interrupts_on_op) |-> stat_reg == ($past(stat_reg) | `IRQ_EN_MASK))
        else $error("interrupts on changed wrong bits");

    halt_bits_kept_a: assert property (
        $past(exec_go && op inside {decimal_add_op, add_carry_decimal_op, decrement_one_op,
                                    decrement_two_op}) |->
            stat_reg[`STAT_OSC_BIT:`STAT_IRQ_EN_BIT] == $past(stat_reg[`STAT_OSC_BIT:`STAT_IRQ_EN_BIT]))
        else $error("arithmetic changed mode bits");

    irq_shadow_a: assert property (
        (exec_go && op == interrupts_on_op) ##1 !exec_go [*2] |-> !irq_take_reg)
        else $error("interrupt taken right after interrupts on");

    cover_bcd_c: cover property (exec_go && op == decimal_add_op ##1 stat_reg[`STAT_C_BIT]);
    cover_sub_c: cover property (exec_go && op == decrement_two_op && byte_sel);
    cover_shadow_c: cover property (shadow_reg && req_sync_reg ##1 exec_go ##2 irq_take_reg);
endmodule
`default_nettype wire

// *** include/exec_unit_consts.svh ***
// Constants for the decimal add, decrement and interrupt enable execution unit.
//
// Notes on behaviour
// - Decimal add negative flag copies result MSB.
// - Decimal add zero flag marks zero result.
// - Decimal add carry marks decimal overflow.
// - Carry-only decimal add carries on rollover.
// - Decrement by one; zero when destination was one.
// - Decrement by one clears carry from zero.
// - Decrement by one overflows from most negative.
// - Decrement negative flag copies result sign.
// - Interrupts off clears enable bit only.
// - Interrupts on sets enable bit only.
// - Enable operations keep flags and halt bits.
// - Arithmetic keeps halt and enable bits.
// - Instruction after interrupts on always runs first.
`ifndef EXEC_UNIT_CONSTS_SVH
`define EXEC_UNIT_CONSTS_SVH

`define ADDR_SRC         8'h00
`define ADDR_DST         8'h01
`define ADDR_STAT        8'h02
`define ADDR_CMD         8'h03
`define ADDR_STATE       8'h04

`define CMD_OP_MSB       2
`define CMD_OP_LSB       0
`define CMD_BYTE_BIT     4

`define OPC_DECIMAL_ADD  3'h1
`define OPC_CARRY_ADD    3'h2
`define OPC_SUB_ONE      3'h3
`define OPC_SUB_TWO      3'h4
`define OPC_IRQ_OFF      3'h5
`define OPC_IRQ_ON       3'h6

`define STAT_C_BIT       0
`define STAT_Z_BIT       1
`define STAT_N_BIT       2
`define STAT_IRQ_EN_BIT  3
`define STAT_CORE_BIT    4
`define STAT_OSC_BIT     5
`define STAT_V_BIT       8

`define STAT_RESET       16'h0000
`define WORD_ZERO        16'h0000
`define IRQ_EN_MASK      16'h0008
`define STEP_ONE         16'h0001
`define STEP_TWO         16'h0002
`define BYTE_MASK        16'h00ff
`define BCD_NINE         5'h09
`define BCD_SIX          5'h06
`define BCD_WORD_MAX     16'h9999
`define BCD_BYTE_MAX     16'h0099
`define WORD_MIN_NEG     16'h8000
`define WORD_MIN_NEG_P1  16'h8001
`define BYTE_MIN_NEG     16'h0080
`define BYTE_MIN_NEG_P1  16'h0081

`endif

// *** include/exec_unit_pkg.sv ***
// Types shared by the execution unit files.
package exec_unit_pkg;
    typedef logic [15:0] word_t;
    typedef logic [3:0]  digit_t;
    typedef enum logic [2:0] {
        op_none,
        decimal_add_op,
        add_carry_decimal_op,
        decrement_one_op,
        decrement_two_op,
        interrupts_off_op,
        interrupts_on_op
    } exec_op_t;
endpackage

// *** testbench/bcd_add_decrement_gie_ops_tb_top.sv ***
// Self-checking testbench for the decimal add, decrement and interrupt enable execution unit.
`timescale 1ns/1ns
`default_nettype none
`include "exec_unit_consts.svh"
module bcd_add_decrement_gie_ops_tb_top;
    import exec_unit_pkg::*;

    // ****************************************************************
    // Signals and stimulus table
    // ****************************************************************
    typedef struct packed {
        logic [2:0] op;
        logic       bsz;
        word_t      src;
        word_t      dst;
        word_t      stat;
        word_t      edst;
        word_t      estat;
        word_t      mask;
    } row_t;

    localparam logic [2:0] da   = `OPC_DECIMAL_ADD;
    localparam logic [2:0] ca   = `OPC_CARRY_ADD;
    localparam logic [2:0] s1   = `OPC_SUB_ONE;
    localparam logic [2:0] s2   = `OPC_SUB_TWO;
    localparam logic [2:0] of   = `OPC_IRQ_OFF;
    localparam logic [2:0] on   = `OPC_IRQ_ON;
    // Overflow is not defined after decimal adds, so it is masked there.
    localparam word_t      md   = 16'hfeff;
    localparam word_t      mall = 16'hffff;

    logic       mclk;
    logic       reset_n;
    logic [7:0] addr;
    word_t      wr_data;
    logic       wr_en;
    logic       rd_en;
    logic       irq_request;
    word_t      rd_data;
    logic       global_irq_enable;
    logic       irq_take;
    logic       exec_done;
    int         num_errors;
    int         n_compared;

    row_t rows [0:29] = '{
        '{da, 1'b0, 16'h1234, 16'h5678, 16'h0038, 16'h6912, 16'h0038, md},
        '{da, 1'b0, 16'h0001, 16'h9999, 16'h0038, 16'h0000, 16'h003b, md},
        '{da, 1'b0, 16'h4000, 16'h4000, 16'h0039, 16'h8001, 16'h003c, md},
        '{da, 1'b1, 16'h0055, 16'h0045, 16'h0000, 16'h0000, 16'h0003, md},
        '{da, 1'b1, 16'h0040, 16'h0039, 16'h0001, 16'h0080, 16'h0004, md},
        '{da, 1'b0, 16'h0001, 16'h0999, 16'h0000, 16'h1000, 16'h0000, md},
        '{da, 1'b0, 16'h9999, 16'h9999, 16'h0001, 16'h9999, 16'h0005, md},
        '{ca, 1'b0, 16'h1111, 16'h9999, 16'h0001, 16'h0000, 16'h0003, md},
        '{ca, 1'b1, 16'h0000, 16'h0099, 16'h0001, 16'h0000, 16'h0003, md},
        '{ca, 1'b0, 16'h0000, 16'h0199, 16'h0031, 16'h0200, 16'h0030, md},
        '{ca, 1'b0, 16'h0000, 16'h1234, 16'h0000, 16'h1234, 16'h0000, md},
        '{s1, 1'b0, 16'h0000, 16'h0001, 16'h0038, 16'h0000, 16'h003b, mall},
        '{s1, 1'b0, 16'h0000, 16'h0000, 16'h0000, 16'hffff, 16'h0004, mall},
        '{s1, 1'b0, 16'h0000, 16'h8000, 16'h0000, 16'h7fff, 16'h0101, mall},
        '{s1, 1'b1, 16'h0000, 16'hab80, 16'h0000, 16'h007f, 16'h0101, mall},
        '{s1, 1'b1, 16'h0000, 16'h0000, 16'h0000, 16'h00ff, 16'h0004, mall},
        '{s1, 1'b0, 16'h0000, 16'h0005, 16'h0107, 16'h0004, 16'h0001, mall},
        '{s2, 1'b0, 16'h0000, 16'h0002, 16'h0030, 16'h0000, 16'h0033, mall},
        '{s2, 1'b0, 16'h0000, 16'h0001, 16'h0000, 16'hffff, 16'h0004, mall},
        '{s2, 1'b0, 16'h0000, 16'h8001, 16'h0000, 16'h7fff, 16'h0101, mall},
        '{s2, 1'b0, 16'h0000, 16'h8000, 16'h0000, 16'h7ffe, 16'h0101, mall},
        '{s2, 1'b1, 16'h0000, 16'h0081, 16'h0000, 16'h007f, 16'h0101, mall},
        '{s2, 1'b1, 16'h0000, 16'h0080, 16'h0000, 16'h007e, 16'h0101, mall},
        '{s2, 1'b1, 16'h0000, 16'h0001, 16'h0000, 16'h00ff, 16'h0004, mall},
        '{s2, 1'b0, 16'h0000, 16'h8002, 16'h0000, 16'h8000, 16'h0005, mall},
        '{s2, 1'b0, 16'h0000, 16'h0000, 16'h0000, 16'hfffe, 16'h0004, mall},
        '{of, 1'b0, 16'h0000, 16'h1234, 16'h013f, 16'h1234, 16'h0137, mall},
        '{on, 1'b0, 16'h0000, 16'h1234, 16'h0137, 16'h1234, 16'h013f, mall},
        '{on, 1'b0, 16'h0000, 16'h4321, 16'h0000, 16'h4321, 16'h0008, mall},
        '{3'h7, 1'b0, 16'h0000, 16'h4321, 16'h0105, 16'h4321, 16'h0105, mall}
    };

    exec_unit uut (
        .mclk              (mclk),
        .reset_n           (reset_n),
        .addr              (addr),
        .wr_data           (wr_data),
        .wr_en             (wr_en),
        .rd_en             (rd_en),
        .irq_request       (irq_request),
        .rd_data           (rd_data),
        .global_irq_enable (global_irq_enable),
        .irq_take          (irq_take),
        .exec_done         (exec_done)
    );

    always #50 mclk = ~mclk;

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic complete_run;
        if (num_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input word_t got, input word_t exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Each call sets every bus signal once and returns just after the sampling edge.
    task automatic bus(input logic [7:0] a, input word_t d, input logic we, input logic re);
        addr    <= a;
        wr_data <= d;
        wr_en   <= we;
        rd_en   <= re;
        @(posedge mclk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input word_t exp, input word_t m);
        bus(a, 16'h0000, 1'b0, 1'b1);
        chk(rd_data & m, exp & m);
    endtask

    task automatic cmd(input logic [2:0] op, input logic bsz);
        bus(`ADDR_CMD, {11'h000, bsz, 1'b0, op}, 1'b1, 1'b0);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        mclk        = 1'b0;
        reset_n     = 1'b0;
        addr        = 8'h00;
        wr_data     = 16'h0000;
        wr_en       = 1'b0;
        rd_en       = 1'b0;
        irq_request = 1'b0;
        num_errors  = 0;
        n_compared  = 0;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        chk({13'h0000, global_irq_enable, irq_take, exec_done}, 16'h0000);
        for (int a = 0; a < 5; a++) begin
            rd(a[7:0], 16'h0000, mall);
        end
        for (int i = 0; i < 30; i++) begin
            bus(`ADDR_SRC, rows[i].src, 1'b1, 1'b0);
            bus(`ADDR_DST, rows[i].dst, 1'b1, 1'b0);
            bus(`ADDR_STAT, rows[i].stat, 1'b1, 1'b0);
            cmd(rows[i].op, rows[i].bsz);
            chk({15'h0000, exec_done}, 16'h0001);
            rd(`ADDR_DST, rows[i].edst, mall);
            chk({15'h0000, exec_done}, 16'h0000);
            rd(`ADDR_STAT, rows[i].estat, rows[i].mask);
            chk({15'h0000, global_irq_enable}, {15'h0000, rows[i].estat[`STAT_IRQ_EN_BIT]});
            rd(`ADDR_SRC, rows[i].src, mall);
        end
        bus(8'h40, 16'hbeef, 1'b1, 1'b0);
        rd(8'h40, 16'h0000, mall);
        rd(`ADDR_CMD, 16'h0000, mall);
        bus(8'h00, 16'h0000, 1'b0, 1'b0);
        chk(rd_data, 16'h0000);
        // The request is pending while interrupts are switched on.
        @(posedge mclk);
        irq_request <= 1'b1;
        bus(`ADDR_STAT, 16'h0000, 1'b1, 1'b0);
        cmd(on, 1'b0);
        for (int k = 0; k < 6; k++) begin
            bus(8'h00, 16'h0000, 1'b0, 1'b0);
            chk({15'h0000, irq_take}, 16'h0000);
        end
        rd(`ADDR_STATE, 16'h0003, mall);
        cmd(3'h0, 1'b0);
        chk({15'h0000, irq_take}, 16'h0001);
        cmd(of, 1'b0);
        cmd(3'h0, 1'b0);
        chk({15'h0000, irq_take}, 16'h0000);
        bus(`ADDR_STAT, 16'h0008, 1'b1, 1'b0);
        bus(8'h00, 16'h0000, 1'b0, 1'b0);
        @(posedge mclk);
        reset_n <= 1'b0;
        irq_request <= 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        chk({13'h0000, global_irq_enable, irq_take, exec_done}, 16'h0000);
        @(posedge mclk);
        reset_n <= 1'b1;
        rd(`ADDR_STAT, 16'h0000, mall);
        rd(`ADDR_DST, 16'h0000, mall);
        bus(8'h00, 16'h0000, 1'b0, 1'b0);
        complete_run();
    end

    // Cuts a hung run short.
    initial begin
        repeat (60000) @(posedge mclk);
        num_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
